//--- sdbd_dma.sv
// Ping-pong DMA engine between a serial FIFO and system RAM, with its APB registers.
// Assumes the FIFO, the transmitter and the RAM port run on mclk_i.
`timescale 1ns/1ps
`include "sdbd_cfg.svh"

// Contract
// R1: A read-only 13-bit offset gives where the next received byte goes in receive buffer A.
// R2: A separate read-only 13-bit offset gives where the next received byte goes in receive buffer B.
// R3: One read-only 13-bit offset gives the next byte position in the loaded transmit buffer.
// R4: Each offset returns to zero once its buffer is full and unloads.
// R5: Receive buffer A has a writable 13-bit start address whose word reads bits 14 and 13 as one and 15 as zero.
// R6: Receive buffer A has a writable 13-bit end address at which it stops accepting bytes.
// R7: Receive buffer B has writable start and end addresses with the same fixed upper bits.
// R8: Transmit buffers A and B have writable start addresses from which bytes are fetched.
// R9: Transmit buffers A and B have writable end addresses that bound the fetch.
// R10: Each receive buffer records only the offset of its first errored byte until reload or receive reset.
// R11: Status shows per-buffer active flags and per-receive-buffer overrun flags given to the next buffer to load.
module sdbd_dma (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Receive FIFO
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_err_i,
  input wire logic rx_overflow_i,
  output logic rx_ready_o,
  // Transmit byte stream
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // RAM port
  output logic ram_req_o,
  output logic ram_we_o,
  output logic [15:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  input wire logic [7:0] ram_rdata_i,
  input wire logic ram_ack_i,
  // Interrupt
  output logic irq_o
);
  import sdbd_pkg::*;

  // ****************************************
  // State and internal signals
  // ****************************************
  sdbd_regs_t s;
  sdbd_regs_t next_s;
  logic [2:0][12:0] cnt;
  logic [2:0] ctr_clear;
  logic [2:0] ctr_step;
  logic [4:0] ev;
  logic [15:0] rd_val;
  logic hit;
  logic acc;
  logic wr;
  logic [29:0] idx;
  logic [12:0] rx_addr;
  logic [12:0] tx_addr;
  logic rx_at_end;
  logic tx_at_end;
  logic [15:0] wd;

  // ****************************************
  // Offset counters
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ctr
      sdbd_offset_ctr u_ctr (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .clear_i(ctr_clear[g]),
        .step_i(ctr_step[g]),
        .count_o(cnt[g])
      );
    end
  endgenerate

  // ****************************************
  // Bus decode and buffer addresses
  // ****************************************
  assign idx = paddr_i[31:2];
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign wd = pwdata_i[15:0];
  assign rx_addr = s.rx_beg[s.rx_sel] + cnt[s.rx_sel]; // R1 R2
  assign tx_addr = s.tx_beg[s.tx_sel] + cnt[2]; // R8 R3
  assign rx_at_end = rx_addr == s.rx_end[s.rx_sel]; // R6 R7
  assign tx_at_end = tx_addr == s.tx_end[s.tx_sel]; // R9

  // ****************************************
  // Register read decode
  // ****************************************
  always_comb begin
    hit = 1'b1;
    rd_val = 16'h0000;
    case (idx)
      `SDBD_IDX_RX_A_START: rd_val = {`SDBD_ADDR_TOP, s.rx_beg[0]}; // R5
      `SDBD_IDX_RX_A_END: rd_val = {`SDBD_ADDR_TOP, s.rx_end[0]}; // R6
      `SDBD_IDX_RX_B_START: rd_val = {`SDBD_ADDR_TOP, s.rx_beg[1]}; // R7
      `SDBD_IDX_RX_B_END: rd_val = {`SDBD_ADDR_TOP, s.rx_end[1]}; // R7
      `SDBD_IDX_TX_A_START: rd_val = {`SDBD_ADDR_TOP, s.tx_beg[0]}; // R8
      `SDBD_IDX_TX_A_END: rd_val = {`SDBD_ADDR_TOP, s.tx_end[0]}; // R9
      `SDBD_IDX_TX_B_START: rd_val = {`SDBD_ADDR_TOP, s.tx_beg[1]}; // R8
      `SDBD_IDX_TX_B_END: rd_val = {`SDBD_ADDR_TOP, s.tx_end[1]}; // R9
      `SDBD_IDX_RX_A_FILL: rd_val = {3'h0, cnt[0]}; // R1
      `SDBD_IDX_RX_B_FILL: rd_val = {3'h0, cnt[1]}; // R2
      `SDBD_IDX_TX_OFFSET: rd_val = {3'h0, cnt[2]}; // R3
      `SDBD_IDX_STATUS: begin
        rd_val[1:0] = s.load[1:0] & {s.rx_sel, ~s.rx_sel}; // R11
        rd_val[3:2] = s.load[3:2] & {s.tx_sel, ~s.tx_sel}; // R11
        rd_val[5:4] = s.ovf; // R11
      end
      `SDBD_IDX_CONTROL: rd_val = {12'h000, s.load};
      `SDBD_IDX_RX_A_ERR: rd_val = {3'h0, s.err[0]}; // R10
      `SDBD_IDX_RX_B_ERR: rd_val = {3'h0, s.err[1]}; // R10
      `SDBD_IDX_INT_STATUS: rd_val = {11'h000, s.int_stat};
      `SDBD_IDX_INT_MASK: rd_val = {11'h000, s.int_mask};
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    ctr_clear = 3'h0;
    ctr_step = 3'h0;
    ev = 5'h00;
    // Read data is captured in the setup cycle and shown in the access cycle.
    if (psel_i && !penable_i) begin
      next_s.prdata = hit ? rd_val : 16'h0000;
    end
    if (wr) begin
      case (idx)
        `SDBD_IDX_RX_A_START: next_s.rx_beg[0] = wd[12:0]; // R5
        `SDBD_IDX_RX_A_END: next_s.rx_end[0] = wd[12:0]; // R6
        `SDBD_IDX_RX_B_START: next_s.rx_beg[1] = wd[12:0]; // R7
        `SDBD_IDX_RX_B_END: next_s.rx_end[1] = wd[12:0]; // R7
        `SDBD_IDX_TX_A_START: next_s.tx_beg[0] = wd[12:0]; // R8
        `SDBD_IDX_TX_A_END: next_s.tx_end[0] = wd[12:0]; // R9
        `SDBD_IDX_TX_B_START: next_s.tx_beg[1] = wd[12:0]; // R8
        `SDBD_IDX_TX_B_END: next_s.tx_end[1] = wd[12:0]; // R9
        `SDBD_IDX_INT_MASK: next_s.int_mask = wd[4:0];
        `SDBD_IDX_CONTROL: begin
          if (wd[`SDBD_CTRL_RX_RESET]) begin
            next_s.load[1:0] = 2'h0;
            next_s.rx_sel = 1'b0;
            next_s.err = '0; // R10
            next_s.err_seen = 2'h0;
            next_s.ovf = 2'h0;
            next_s.ovf_pend = 1'b0;
            ctr_clear[1:0] = 2'h3;
          end
          if (wd[`SDBD_CTRL_TX_RESET]) begin
            next_s.load[3:2] = 2'h0;
            next_s.tx_sel = 1'b0;
            ctr_clear[2] = 1'b1;
          end
          // Writing zero to a load bit has no effect.
          for (int b = 0; b < 2; b++) begin
            if (wd[b]) begin
              next_s.err[b] = 13'h0000; // R10
              next_s.err_seen[b] = 1'b0;
              next_s.ovf[b] = 1'b0;
            end
          end
          next_s.load = next_s.load | wd[3:0];
        end
        default: ;
      endcase
    end
    // Transfer engine: receive has priority over transmit on the RAM port.
    case (s.st)
      SDBD_IDLE: begin
        if (rx_valid_i && s.load[s.rx_sel]) begin
          next_s.data = rx_data_i;
          next_s.data_err = rx_err_i;
          next_s.addr = {`SDBD_ADDR_TOP, rx_addr};
          next_s.st = SDBD_RX_WRITE;
        end else if (s.load[{1'b1, s.tx_sel}]) begin
          next_s.addr = {`SDBD_ADDR_TOP, tx_addr}; // R8
          next_s.st = SDBD_TX_READ;
        end
      end
      SDBD_RX_WRITE: begin
        if (ram_ack_i) begin
          next_s.st = SDBD_IDLE;
          if (next_s.load[s.rx_sel]) begin
            if (s.data_err && !s.err_seen[s.rx_sel]) begin
              next_s.err[s.rx_sel] = cnt[s.rx_sel]; // R10
              next_s.err_seen[s.rx_sel] = 1'b1; // R10
            end
            if (rx_at_end) begin
              next_s.load[s.rx_sel] = 1'b0; // R6
              next_s.rx_sel = ~s.rx_sel;
              ctr_clear[s.rx_sel] = 1'b1; // R4
              ev[s.rx_sel] = 1'b1;
            end else begin
              ctr_step[s.rx_sel] = 1'b1; // R1 R2
            end
          end
        end
      end
      SDBD_TX_READ: begin
        if (ram_ack_i) begin
          next_s.data = ram_rdata_i;
          next_s.st = SDBD_TX_OUT;
        end
      end
      SDBD_TX_OUT: begin
        if (tx_ready_i) begin
          next_s.st = SDBD_IDLE;
          if (next_s.load[{1'b1, s.tx_sel}]) begin
            if (tx_at_end) begin
              next_s.load[{1'b1, s.tx_sel}] = 1'b0; // R9
              next_s.tx_sel = ~s.tx_sel;
              ctr_clear[2] = 1'b1; // R4
              ev[{1'b1, s.tx_sel}] = 1'b1;
            end else begin
              ctr_step[2] = 1'b1; // R3
            end
          end
        end
      end
      default: next_s.st = SDBD_IDLE;
    endcase
    // Overflow with no loaded buffer is charged to the next buffer to load.
    if (rx_overflow_i && !s.load[s.rx_sel]) begin
      next_s.ovf_pend = 1'b1; // R11
      ev[`SDBD_EV_OVERRUN] = 1'b1;
    end
    if (next_s.ovf_pend && next_s.load[next_s.rx_sel]) begin
      next_s.ovf[next_s.rx_sel] = 1'b1; // R11
      next_s.ovf_pend = 1'b0;
    end
    // A status read clears only the bits it returned; a new event wins.
    next_s.int_stat = s.int_stat | ev;
    if (acc && !pwrite_i && idx == `SDBD_IDX_INT_STATUS) begin
      next_s.int_stat = (s.int_stat & ~s.prdata[4:0]) | ev;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.st <= SDBD_IDLE;
      s.int_mask <= `SDBD_MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_o = {16'h0000, s.prdata};
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~hit;
  assign rx_ready_o = (s.st == SDBD_IDLE) & s.load[s.rx_sel];
  assign tx_valid_o = s.st == SDBD_TX_OUT;
  assign tx_data_o = s.data;
  assign ram_req_o = (s.st == SDBD_RX_WRITE) | (s.st == SDBD_TX_READ);
  assign ram_we_o = s.st == SDBD_RX_WRITE;
  assign ram_addr_o = s.addr;
  assign ram_wdata_o = s.data;
  assign irq_o = |(s.int_stat & s.int_mask);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  rx_a_step_a: assert property (ctr_step[0] && !ctr_clear[0] |=> cnt[0] == $past(cnt[0]) + 13'h0001) // R1
    else $error("rx A offset did not advance");
  rx_b_step_a: assert property (ctr_step[1] && !ctr_clear[1] |=> cnt[1] == $past(cnt[1]) + 13'h0001) // R2
    else $error("rx B offset did not advance");
  tx_step_a: assert property (s.st == SDBD_TX_OUT && tx_ready_i && s.load[{1'b1, s.tx_sel}] && !tx_at_end
      && !wr |=> cnt[2] == $past(cnt[2]) + 13'h0001) // R3
    else $error("tx offset did not advance");
  unload_wrap_a: assert property (ev[0] |=> cnt[0] == 13'h0000 && !s.load[0]) // R4
    else $error("rx A offset did not wrap");
  start_top_a: assert property (psel_i && !penable_i && idx == `SDBD_IDX_RX_A_START
      |=> prdata_o[15:13] == 3'h3) // R5
    else $error("start word fixed bits wrong");
  end_stop_a: assert property (s.st == SDBD_RX_WRITE && ram_ack_i && !s.rx_sel && s.load[0] && rx_at_end
      |=> !s.load[0] ##1 !(rx_ready_o && !s.rx_sel)) // R6
    else $error("rx A accepted past its end");
  b_end_top_a: assert property (psel_i && !penable_i && idx == `SDBD_IDX_RX_B_END
      |=> prdata_o[15:13] == 3'h3) // R7
    else $error("rx B end fixed bits wrong");
  tx_fetch_a: assert property (s.st == SDBD_IDLE && !rx_ready_o && s.load[{1'b1, s.tx_sel}] && cnt[2] == 13'h0000
      |=> ram_req_o && !ram_we_o && ram_addr_o[12:0] == $past(s.tx_beg[s.tx_sel])) // R8
    else $error("tx fetch not from start");
  first_err_a: assert property (s.err_seen[0] && !wr |=> $stable(s.err[0])) // R10
    else $error("first error offset overwritten");
  overrun_flag_a: assert property (s.ovf_pend && !wr |-> !s.load[s.rx_sel]) // R11
    else $error("overrun pending while buffer loaded");
  rx_b_wrap_a: assert property (ev[1] |=> cnt[1] == 13'h0000 && !s.load[1]) // R4
    else $error("rx B offset did not wrap");
  tx_unload_a: assert property (ev[2] |=> cnt[2] == 13'h0000 && !s.load[2]) // R9
    else $error("tx A did not unload at its end");
  first_err_b_a: assert property (s.err_seen[1] && !wr |=> $stable(s.err[1])) // R10
    else $error("rx B first error offset overwritten");
  a_end_top_a: assert property (psel_i && !penable_i && idx == `SDBD_IDX_RX_A_END // R6
      |=> prdata_o[15:13] == 3'h3)
    else $error("rx A end fixed bits wrong");
  tx_start_top_a: assert property (psel_i && !penable_i && idx == `SDBD_IDX_TX_A_START // R8
      |=> prdata_o[15:13] == 3'h3)
    else $error("tx A start fixed bits wrong");
  tx_end_top_a: assert property (psel_i && !penable_i && idx == `SDBD_IDX_TX_B_END // R9
      |=> prdata_o[15:13] == 3'h3)
    else $error("tx B end fixed bits wrong");
  rx_active_a: assert property (psel_i && !penable_i && idx == `SDBD_IDX_STATUS && s.load[0] && !s.rx_sel // R11
      |=> prdata_o[0])
    else $error("rx A active flag missing");
  rx_req_a: assert property (rx_valid_i && rx_ready_o // R1
      |=> ram_req_o && ram_we_o && ram_addr_o == {`SDBD_ADDR_TOP, $past(rx_addr)})
    else $error("rx byte not written at its offset");
  ram_hold_a: assert property (ram_req_o && !ram_ack_i |=> ram_req_o && $stable(ram_addr_o)) // R8
    else $error("RAM request dropped before acknowledge");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) // R3
    else $error("tx byte dropped before accept");
  rx_reset_a: assert property (wr && idx == `SDBD_IDX_CONTROL && pwdata_i[`SDBD_CTRL_RX_RESET] // R10
      && pwdata_i[1:0] == 2'h0 |=> cnt[0] == 13'h0000 && cnt[1] == 13'h0000 && s.err == '0)
    else $error("rx DMA reset left offsets or errors");
  overrun_pend_a: assert property (rx_overflow_i && !s.load[s.rx_sel] && !wr |=> s.ovf_pend) // R11
    else $error("overrun not held for the next buffer");
  unmapped_zero_a: assert property (psel_i && !penable_i && !hit
      |=> prdata_o == 32'h00000000)
    else $error("unmapped read returned data");
  event_sticky_a: assert property (ev[0] |=> s.int_stat[0])
    else $error("rx A unload event lost");

endmodule : sdbd_dma

//--- sdbd_cfg.svh
// Offsets, field positions and reset values of the dual buffer DMA block.
// Assumes a 32-bit APB bus where each register index sits at byte address index*4.
`ifndef SDBD_CFG_SVH
`define SDBD_CFG_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define SDBD_IDX_RX_A_START 30'h4400
`define SDBD_IDX_RX_A_END 30'h4402
`define SDBD_IDX_RX_B_START 30'h4404
`define SDBD_IDX_RX_B_END 30'h4406
`define SDBD_IDX_TX_A_START 30'h4408
`define SDBD_IDX_TX_A_END 30'h440a
`define SDBD_IDX_TX_B_START 30'h440c
`define SDBD_IDX_TX_B_END 30'h440e
`define SDBD_IDX_RX_A_FILL 30'h4410
`define SDBD_IDX_RX_B_FILL 30'h4412
`define SDBD_IDX_TX_OFFSET 30'h4414
`define SDBD_IDX_STATUS 30'h4416
`define SDBD_IDX_CONTROL 30'h4418
`define SDBD_IDX_RX_A_ERR 30'h441a
`define SDBD_IDX_RX_B_ERR 30'h441c
`define SDBD_IDX_INT_STATUS 30'h4430
`define SDBD_IDX_INT_MASK 30'h4432

// ****************************************
// Field positions and fixed bits
// ****************************************
`define SDBD_ADDR_TOP 3'h3
`define SDBD_CTRL_RX_RESET 4
`define SDBD_CTRL_TX_RESET 5
`define SDBD_EV_OVERRUN 4

// ****************************************
// Reset values
// ****************************************
`define SDBD_ADDR_RESET 13'h0000
`define SDBD_MASK_RESET 5'h00

`endif

//--- sdbd_pkg.sv
// Types shared by the dual buffer DMA block.
// Assumes sdbd_cfg.svh supplies the numeric constants.
package sdbd_pkg;

  typedef enum logic [3:0] {
    SDBD_IDLE = 4'h1,
    SDBD_RX_WRITE = 4'h2,
    SDBD_TX_READ = 4'h4,
    SDBD_TX_OUT = 4'h8
  } sdbd_state_t;

  typedef struct packed {
    sdbd_state_t st;
    logic [1:0][12:0] rx_beg;
    logic [1:0][12:0] rx_end;
    logic [1:0][12:0] tx_beg;
    logic [1:0][12:0] tx_end;
    logic [3:0] load;
    logic rx_sel;
    logic tx_sel;
    logic [1:0][12:0] err;
    logic [1:0] err_seen;
    logic [1:0] ovf;
    logic ovf_pend;
    logic [7:0] data;
    logic data_err;
    logic [15:0] addr;
    logic [15:0] prdata;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
  } sdbd_regs_t;

  typedef struct packed {
    logic [12:0] count;
  } sdbd_ctr_t;

endpackage : sdbd_pkg

//--- sdbd_offset_ctr.sv
// Byte offset counter of one DMA buffer.
// Assumes clear and step come from logic on the same clock.
`timescale 1ns/1ps
module sdbd_offset_ctr (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Control
  input wire logic clear_i,
  input wire logic step_i,
  // Offset
  output logic [12:0] count_o
);
  import sdbd_pkg::*;

  sdbd_ctr_t s;
  sdbd_ctr_t next_s;

  always_comb begin
    next_s = s;
    if (clear_i) begin
      next_s.count = 13'h0000;
    end else if (step_i) begin
      next_s.count = s.count + 13'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_o = s.count;

endmodule : sdbd_offset_ctr

//--- sdbd_far_model.sv
// Far side of the DMA block: byte RAM with optional wait states and a transmit byte sink.
// Assumes one clock shared with the block and requests held until acknowledged.
`timescale 1ns/1ps
module sdbd_far_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Wait states on
  input wire logic slow_i,
  // RAM port
  input wire logic ram_req_i,
  input wire logic ram_we_i,
  input wire logic [15:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  output logic [7:0] ram_rdata_o,
  output logic ram_ack_o,
  // Transmit sink
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] mem [0:8191];
  logic [2:0] wait_cnt;
  logic bad_addr;
  logic busy;
  logic [2:0] dly;
  assign busy = (ram_req_i && !ram_ack_o) || (tx_valid_i && !tx_ready_o);
  assign dly = slow_i ? 3'h3 : 3'h0;
  // ****************************************
  // RAM and sink
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ram_ack_o <= 1'b0;
      tx_ready_o <= 1'b0;
      wait_cnt <= 3'h0;
      bad_addr <= 1'b0;
      ram_rdata_o <= 8'h5a;
    end else begin
      wait_cnt <= busy ? wait_cnt + 3'h1 : 3'h0;
      ram_ack_o <= 1'b0;
      tx_ready_o <= 1'b0;
      // The read bus toggles while released so a stale byte is never mistaken for data.
      ram_rdata_o <= ~ram_rdata_o;
      if (ram_req_i && !ram_ack_o && wait_cnt >= dly) begin
        ram_ack_o <= 1'b1;
        if (ram_addr_i[15:13] !== 3'h3) bad_addr <= 1'b1;
        if (ram_we_i) mem[ram_addr_i[12:0]] <= ram_wdata_i;
        else ram_rdata_o <= mem[ram_addr_i[12:0]];
      end
      if (tx_valid_i && !tx_ready_o && wait_cnt >= dly) tx_ready_o <= 1'b1;
    end
  end
endmodule : sdbd_far_model

//--- serial_ctrl_dual_buffer_dma_bench.sv
// Self-checking bench of the dual buffer DMA block.
// Assumes the far side model and the register indices of sdbd_cfg.svh.
`timescale 1ns/1ps
`include "sdbd_cfg.svh"
module serial_ctrl_dual_buffer_dma_bench;
  logic mclk_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic rx_valid = 0, rx_err = 0, rx_ovf = 0, pready, pslverr, rx_ready, tx_valid, tx_ready, ram_req, ram_we;
  logic [7:0] rx_data = 0, tx_data, ram_wdata, ram_rdata;
  logic [15:0] ram_addr;
  logic ram_ack, irq;
  logic [7:0] txq[$];
  int errors = 0, n_compared = 0;
  always #20 mclk_i = ~mclk_i;
  sdbd_dma i_sdbd_dma (.mclk_i(mclk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_err_i(rx_err),
    .rx_overflow_i(rx_ovf), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .ram_req_o(ram_req), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
    .ram_wdata_o(ram_wdata), .ram_rdata_i(ram_rdata), .ram_ack_i(ram_ack), .irq_o(irq));
  sdbd_far_model i_sdbd_far_model (.mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(slow),
    .ram_req_i(ram_req), .ram_we_i(ram_we), .ram_addr_i(ram_addr), .ram_wdata_i(ram_wdata),
    .ram_rdata_o(ram_rdata), .ram_ack_o(ram_ack), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
  always @(posedge mclk_i) if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic complete_run;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [29:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    psel <= 1'b1;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= {16'h0000, wd};
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [29:0] idx, input logic [15:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, v, d, e);
  endtask : wr
  task automatic rd(input logic [29:0] idx, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 16'h0000, d, e);
    cmp(nm, exp, d);
  endtask : rd
  task automatic rx_byte(input logic [7:0] d, input logic e);
    int n;
    @(posedge mclk_i);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_err <= e;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rx_ready !== 1'b1 && n < 50);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ram_ack !== 1'b1 && n < 50);
    cmp("rx byte done", 32'h1, {31'h0, n < 50});
  endtask : rx_byte
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic e;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(30'h4400 + 30'(2 * i), 32'h6000, "addr reset");
      wr(30'h4400 + 30'(2 * i), 16'hffff ^ 16'(i));
      rd(30'h4400 + 30'(2 * i), 32'h6000 | (32'h1fff ^ 32'(i)), "addr rw");
    end
    apb(1'b0, 30'h4500, 16'h0000, d, e);
    cmp("unmapped err", 32'h1, {31'h0, e});
    cmp("unmapped data", 32'h0, d);
    wr(`SDBD_IDX_RX_A_START, 16'h0010);
    wr(`SDBD_IDX_RX_A_END, 16'h0012);
    wr(`SDBD_IDX_RX_B_START, 16'h0020);
    wr(`SDBD_IDX_RX_B_END, 16'h0021);
    wr(`SDBD_IDX_TX_A_START, 16'h0010);
    wr(`SDBD_IDX_TX_A_END, 16'h0011);
    wr(`SDBD_IDX_CONTROL, 16'h0003);
    rd(`SDBD_IDX_STATUS, 32'h01, "status rx a");
    rx_byte(8'ha0, 1'b0);
    rx_byte(8'ha1, 1'b1);
    rd(`SDBD_IDX_RX_A_FILL, 32'h2, "fill a");
    rd(`SDBD_IDX_RX_A_ERR, 32'h1, "err a");
    rx_byte(8'ha2, 1'b1);
    rd(`SDBD_IDX_RX_A_FILL, 32'h0, "fill a wrap");
    rd(`SDBD_IDX_RX_A_ERR, 32'h1, "err a held");
    rd(`SDBD_IDX_STATUS, 32'h02, "status rx b");
    rd(`SDBD_IDX_CONTROL, 32'h02, "load bits");
    @(posedge mclk_i);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(`SDBD_IDX_INT_MASK, 16'h001f);
    @(posedge mclk_i);
    cmp("irq on", 32'h1, {31'h0, irq});
    rd(`SDBD_IDX_INT_STATUS, 32'h01, "int rx a");
    @(posedge mclk_i);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    rx_byte(8'hb0, 1'b0);
    rd(`SDBD_IDX_RX_B_FILL, 32'h1, "fill b");
    rx_byte(8'hb1, 1'b1);
    rd(`SDBD_IDX_RX_B_FILL, 32'h0, "fill b wrap");
    rd(`SDBD_IDX_RX_B_ERR, 32'h1, "err b");
    rd(`SDBD_IDX_INT_STATUS, 32'h02, "int rx b");
    @(posedge mclk_i);
    cmp("rx refused", 32'h0, {31'h0, rx_ready});
    cmp("ram a0", 32'ha0, {24'h0, i_sdbd_far_model.mem[16]});
    cmp("ram a2", 32'ha2, {24'h0, i_sdbd_far_model.mem[18]});
    cmp("ram b1", 32'hb1, {24'h0, i_sdbd_far_model.mem[33]});
    cmp("ram top", 32'h0, {31'h0, i_sdbd_far_model.bad_addr});
    rx_ovf <= 1'b1;
    @(posedge mclk_i);
    rx_ovf <= 1'b0;
    wr(`SDBD_IDX_CONTROL, 16'h0001);
    rd(`SDBD_IDX_STATUS, 32'h11, "overrun a");
    rd(`SDBD_IDX_RX_A_ERR, 32'h0, "err a reload");
    slow <= 1'b1;
    wr(`SDBD_IDX_CONTROL, 16'h0004);
    for (int n = 0; n < 200 && txq.size() < 1; n++) @(posedge mclk_i);
    rd(`SDBD_IDX_TX_OFFSET, 32'h1, "tx offset");
    for (int n = 0; n < 200 && txq.size() < 2; n++) @(posedge mclk_i);
    repeat (30) @(posedge mclk_i);
    cmp("tx count", 32'h2, 32'(txq.size()));
    cmp("tx byte 0", 32'ha0, {24'h0, txq[0]});
    cmp("tx byte 1", 32'ha1, {24'h0, txq[1]});
    rd(`SDBD_IDX_TX_OFFSET, 32'h0, "tx wrap");
    rd(`SDBD_IDX_STATUS, 32'h11, "tx done");
    wr(`SDBD_IDX_CONTROL, 16'h0010);
    rd(`SDBD_IDX_STATUS, 32'h0, "rx reset");
    rd(`SDBD_IDX_RX_B_ERR, 32'h0, "err b reset");
    complete_run();
  end
endmodule : serial_ctrl_dual_buffer_dma_bench
